// File: src/osd_core.sv
// Execution sequencer for the opcode subset: fetch, operands, stacking, halt
// Function
// - Subtract memory from accumulator; N,Z,C updated
// - Subtract cycles: 2,3,4,5,4,3 by mode
// - Trap advances PC, pushes five bytes
// - Trap sets mask, loads PC from vector
// - Accumulator-to-index move, no flags, two cycles
// - Index-to-accumulator move, no flags, two cycles
// - Check operand minus zero; N,Z only
// - Check cycles: 4,3,3,5,4 by mode
// - Wait clears mask and halts the core
// - 16-bit offset: high then low, plus index
// - Long absolute: address high byte then low
// - 8-bit offset byte added to index
// - Bit-branch fetches address then branch offset
// - Trap return pulls five bytes, SP pre-incremented
`timescale 1ns/1ps
`default_nettype none
`include "osd_defs.svh"
module osd_core
  import osd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic wake_i,
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  output logic [7:0] acc_o,
  output logic [7:0] index_o,
  output logic [4:0] flags_o,
  output logic [15:0] pc_o,
  output logic [7:0] sp_o,
  output logic halted_o,
  output logic done_o,
  output logic illegal_o
);
  osd_state_e state, next_state;
  logic [3:0] cyc, next_cyc;
  logic [15:0] pc, next_pc, ea, next_ea;
  logic [7:0] sp, next_sp, acc, next_acc, x, next_x, opc, next_opc, rel, next_rel;
  logic [4:0] flag_register, next_ccr;
  logic [2:0] cnt, next_cnt;
  logic next_ill;
  logic [8:0] diff;
  logic [15:0] shifted;
  logic tested_bit;
  osd_state_e fin_state;

  osd_dec_if dec_bus();

  osd_decode u_dec (
    .d(dec_bus.decoder)
  );

  // Negative and zero flags of a byte
  function automatic logic [1:0] nz_of(input logic [7:0] v);
    nz_of = {v[7], v == 8'h00};
  endfunction

  // The decoder looks at the fetched byte during fetch, at the latched opcode after
  assign dec_bus.opcode = (state == ST_FETCH) ? mem_rdata_i : opc;
  assign fin_state = (cyc == dec_bus.cycles) ? ST_FETCH : ST_PAD;
  assign shifted = {ea[7:0], mem_rdata_i};
  assign diff = {1'b0, acc} - {1'b0, mem_rdata_i};
  assign tested_bit = mem_rdata_i[opc[3:1]];

  // Next-state and datapath decisions
  always_comb begin
    next_state = state;
    next_cyc = cyc + 4'h1;
    next_pc = pc;
    next_sp = sp;
    next_acc = acc;
    next_x = x;
    next_ccr = flag_register;
    next_opc = opc;
    next_ea = ea;
    next_rel = rel;
    next_cnt = cnt;
    next_ill = 1'b0;
    case (state)
      ST_FETCH: begin
        next_opc = mem_rdata_i;
        next_pc = pc + 16'h0001;
        next_cnt = 3'h0;
        next_ea = 16'h0000;
        case (dec_bus.mode)
          MD_LIT: begin
            next_ea = pc + 16'h0001;
            next_pc = pc + 16'h0002;
            next_state = ST_MEMRD;
          end
          MD_IX: begin
            next_ea = {`OSD_PAGE0, x};
            next_state = ST_MEMRD;
          end
          MD_DIR, MD_LONG, MD_OFS8, MD_OFS16, MD_BTB: begin
            next_state = ST_OPND;
          end
          default: begin
            if (dec_bus.op == OP_TRAP) begin
              next_state = ST_PUSH;
            end else if (dec_bus.op == OP_TRET) begin
              next_sp = sp + 8'h01;
              next_state = ST_PULL;
            end else begin
              next_state = ST_EXEC;
            end
          end
        endcase
      end
      ST_EXEC: begin
        next_state = fin_state;
        case (dec_bus.op)
          OP_A2X: next_x = acc;
          OP_X2A: next_acc = x;
          OP_CHKA: next_ccr[`OSD_CCR_N:`OSD_CCR_Z] = nz_of(acc);
          OP_CHKX: next_ccr[`OSD_CCR_N:`OSD_CCR_Z] = nz_of(x);
          OP_WAIT: begin
            next_ccr[`OSD_CCR_I] = 1'b0;
            next_state = ST_HALT;
          end
          default: next_ill = 1'b1;
        endcase
      end
      ST_OPND: begin
        next_pc = pc + 16'h0001;
        next_cnt = cnt + 3'h1;
        if ((cnt + 3'h1) < {1'b0, dec_bus.nbytes}) begin
          next_ea = shifted;
        end else begin
          next_state = ST_MEMRD;
          case (dec_bus.mode)
            MD_LONG: next_ea = shifted;
            MD_OFS16: next_ea = shifted + {`OSD_PAGE0, x};
            MD_OFS8: next_ea = {`OSD_PAGE0, mem_rdata_i} + {`OSD_PAGE0, x};
            MD_BTB: next_rel = mem_rdata_i;
            default: next_ea = {`OSD_PAGE0, mem_rdata_i};
          endcase
        end
      end
      ST_MEMRD: begin
        next_state = fin_state;
        case (dec_bus.op)
          OP_SUB: begin
            next_acc = diff[7:0];
            next_ccr[`OSD_CCR_N:`OSD_CCR_Z] = nz_of(diff[7:0]);
            next_ccr[`OSD_CCR_C] = diff[8];
          end
          OP_BTB: begin
            next_ccr[`OSD_CCR_C] = tested_bit;
            if (tested_bit ^ opc[0]) begin
              next_pc = pc + {{8{rel[7]}}, rel};
            end
          end
          default: next_ccr[`OSD_CCR_N:`OSD_CCR_Z] = nz_of(mem_rdata_i);
        endcase
      end
      ST_PUSH: begin
        next_sp = sp - 8'h01;
        next_cnt = cnt + 3'h1;
        if (cnt == `OSD_LAST_STK) begin
          next_ccr[`OSD_CCR_I] = 1'b1;
          next_cnt = 3'h0;
          next_state = ST_VECT;
        end
      end
      ST_VECT: begin
        if (cnt == 3'h0) begin
          next_pc = {mem_rdata_i, pc[7:0]};
          next_cnt = 3'h1;
        end else begin
          next_pc = {pc[15:8], mem_rdata_i};
          next_state = fin_state;
        end
      end
      ST_PULL: begin
        // flags, A, X, PC high, PC low
        case (cnt)
          3'h0: next_ccr = mem_rdata_i[4:0];
          3'h1: next_acc = mem_rdata_i;
          3'h2: next_x = mem_rdata_i;
          3'h3: next_pc = {mem_rdata_i, pc[7:0]};
          default: next_pc = {pc[15:8], mem_rdata_i};
        endcase
        if (cnt == `OSD_LAST_STK) begin
          next_state = fin_state;
        end else begin
          next_sp = sp + 8'h01;
          next_cnt = cnt + 3'h1;
        end
      end
      ST_HALT: begin
        next_cyc = cyc;
        if (wake_i) begin
          next_state = ST_FETCH;
        end
      end
      default: next_state = fin_state;
    endcase
    if (next_state == ST_FETCH) begin
      next_cyc = 4'h1;
    end
  end

  // Bus request for the coming cycle, derived from where the sequencer goes
  wire next_rd = (next_state == ST_FETCH) | (next_state == ST_OPND) | (next_state == ST_MEMRD) |
                 (next_state == ST_VECT) | (next_state == ST_PULL);
  wire next_wr = (next_state == ST_PUSH);
  wire [15:0] stack_addr = {`OSD_PAGE0, next_sp};
  wire [15:0] vect_addr = (next_cnt == 3'h0) ? `OSD_VEC_TRAP_HI : `OSD_VEC_TRAP_LO;
  wire [15:0] next_addr = (next_state == ST_FETCH || next_state == ST_OPND) ? next_pc :
                          (next_state == ST_MEMRD) ? next_ea :
                          (next_state == ST_PUSH || next_state == ST_PULL) ? stack_addr :
                          (next_state == ST_VECT) ? vect_addr : 16'h0000;
  // push order PC low, PC high, X, A, flags
  wire [7:0] next_wdata = (next_cnt == 3'h0) ? next_pc[7:0] :
                          (next_cnt == 3'h1) ? next_pc[15:8] :
                          (next_cnt == 3'h2) ? next_x :
                          (next_cnt == 3'h3) ? next_acc : {`OSD_CCR_PAD, next_ccr};
  wire next_done = (next_state == ST_FETCH) && (state != ST_HALT);
  wire next_halt = (next_state == ST_HALT);

  // Architectural state and sequencer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_FETCH;
      cyc <= 4'h1;
      pc <= `OSD_RST_PC;
      sp <= `OSD_RST_SP;
      acc <= `OSD_RST_ACC;
      x <= `OSD_RST_X;
      flag_register <= `OSD_RST_CCR;
      opc <= 8'h00;
      ea <= 16'h0000;
      rel <= 8'h00;
      cnt <= 3'h0;
    end else begin
      state <= next_state;
      cyc <= next_cyc;
      pc <= next_pc;
      sp <= next_sp;
      acc <= next_acc;
      x <= next_x;
      flag_register <= next_ccr;
      opc <= next_opc;
      ea <= next_ea;
      rel <= next_rel;
      cnt <= next_cnt;
    end
  end

  // Registered memory strobes and status outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_addr_o <= `OSD_RST_PC;
      mem_rd_o <= 1'b1;
      mem_wr_o <= 1'b0;
      mem_wdata_o <= 8'h00;
      halted_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
    end else begin
      mem_addr_o <= next_addr;
      mem_rd_o <= next_rd;
      mem_wr_o <= next_wr;
      mem_wdata_o <= next_wr ? next_wdata : 8'h00;
      halted_o <= next_halt;
      done_o <= next_done;
      illegal_o <= next_ill;
    end
  end

  assign acc_o = acc;
  assign index_o = x;
  assign flags_o = flag_register;
  assign pc_o = pc;
  assign sp_o = sp;
endmodule
`default_nettype wire

// File: pkg/osd_defs.svh
// Constants of the opcode subset decoder: opcodes, cycle counts, reset values
`ifndef OSD_DEFS_SVH
`define OSD_DEFS_SVH
// Single-byte opcodes
`define OSD_OPC_TRAP 8'h83
`define OSD_OPC_TRAP_RET 8'h80
`define OSD_OPC_A2X 8'h97
`define OSD_OPC_X2A 8'h9F
`define OSD_OPC_WAIT 8'h8F
// Opcode nibbles of the subtract, check and bit-branch groups
`define OSD_SUB_LO 4'h0
`define OSD_CHK_LO 4'hD
`define OSD_HI_LIT 4'hA
`define OSD_HI_DIR 4'hB
`define OSD_HI_LONG 4'hC
`define OSD_HI_OFS16 4'hD
`define OSD_HI_OFS8 4'hE
`define OSD_HI_IX 4'hF
`define OSD_HI_CHK_DIR 4'h3
`define OSD_HI_CHK_A 4'h4
`define OSD_HI_CHK_X 4'h5
`define OSD_HI_CHK_OFS8 4'h6
`define OSD_HI_CHK_IX 4'h7
`define OSD_HI_BTB 4'h0
// Cycle counts per instruction and mode
`define OSD_CYC_SUB_LIT 4'h2
`define OSD_CYC_SUB_DIR 4'h3
`define OSD_CYC_SUB_LONG 4'h4
`define OSD_CYC_SUB_OFS16 4'h5
`define OSD_CYC_SUB_OFS8 4'h4
`define OSD_CYC_SUB_IX 4'h3
`define OSD_CYC_CHK_DIR 4'h4
`define OSD_CYC_CHK_A 4'h3
`define OSD_CYC_CHK_X 4'h3
`define OSD_CYC_CHK_OFS8 4'h5
`define OSD_CYC_CHK_IX 4'h4
`define OSD_CYC_TRAP 4'hA
`define OSD_CYC_TRAP_RET 4'h9
`define OSD_CYC_MOVE 4'h2
`define OSD_CYC_WAIT 4'h2
`define OSD_CYC_BTB 4'h5
`define OSD_CYC_ILL 4'h2
// Flag register bit positions and stacked padding
`define OSD_CCR_H 4
`define OSD_CCR_I 3
`define OSD_CCR_N 2
`define OSD_CCR_Z 1
`define OSD_CCR_C 0
`define OSD_CCR_PAD 3'h7
// Reset values and fixed addresses
`define OSD_RST_PC 16'h0100
`define OSD_RST_SP 8'hFF
`define OSD_RST_CCR 5'h08
`define OSD_RST_ACC 8'h00
`define OSD_RST_X 8'h00
`define OSD_VEC_TRAP_HI 16'hFFFC
`define OSD_VEC_TRAP_LO 16'hFFFD
`define OSD_PAGE0 8'h00
`define OSD_LAST_STK 3'h4
`endif

// File: pkg/osd_pkg.sv
// Types shared by the opcode subset decoder modules
package osd_pkg;
  typedef enum logic [2:0] {
    MD_INH, MD_LIT, MD_DIR, MD_LONG, MD_OFS16, MD_OFS8, MD_IX, MD_BTB
  } osd_mode_e;
  typedef enum logic [3:0] {
    OP_ILL, OP_SUB, OP_CHK, OP_CHKA, OP_CHKX, OP_A2X, OP_X2A, OP_TRAP, OP_TRET, OP_WAIT, OP_BTB
  } osd_op_e;
  typedef enum logic [8:0] {
    ST_FETCH = 9'h001,
    ST_EXEC = 9'h002,
    ST_OPND = 9'h004,
    ST_MEMRD = 9'h008,
    ST_PUSH = 9'h010,
    ST_VECT = 9'h020,
    ST_PULL = 9'h040,
    ST_PAD = 9'h080,
    ST_HALT = 9'h100
  } osd_state_e;
endpackage

// File: pkg/osd_dec_if.sv
// Opcode in, decoded class, mode, cycle count and operand bytes out
`timescale 1ns/1ps
`default_nettype none
interface osd_dec_if;
  import osd_pkg::*;
  logic [7:0] opcode;
  osd_mode_e mode;
  osd_op_e op;
  logic [3:0] cycles;
  logic [1:0] nbytes;
  modport decoder (input opcode, output mode, output op, output cycles, output nbytes);
  modport core (output opcode, input mode, input op, input cycles, input nbytes);
endinterface
`default_nettype wire

// File: src/osd_decode.sv
// Opcode decoder: instruction class, addressing mode and total cycle count
`timescale 1ns/1ps
`default_nettype none
`include "osd_defs.svh"
module osd_decode
  import osd_pkg::*;
(
  osd_dec_if.decoder d
);
  wire [3:0] hi = d.opcode[7:4];
  wire [3:0] lo = d.opcode[3:0];

  // Address bytes that follow the opcode in each mode
  function automatic logic [1:0] mode_bytes(input osd_mode_e m);
    case (m)
      MD_DIR, MD_OFS8: mode_bytes = 2'h1;
      MD_LONG, MD_OFS16, MD_BTB: mode_bytes = 2'h2;
      default: mode_bytes = 2'h0;
    endcase
  endfunction

  // Class, mode and length lookup
  always_comb begin
    d.mode = MD_INH;
    d.op = OP_ILL;
    d.cycles = `OSD_CYC_ILL;
    if (hi == `OSD_HI_BTB) begin
      d.mode = MD_BTB;
      d.op = OP_BTB;
      d.cycles = `OSD_CYC_BTB;
    end else if (lo == `OSD_SUB_LO && hi >= `OSD_HI_LIT) begin
      d.op = OP_SUB;
      case (hi)
        `OSD_HI_LIT: begin d.mode = MD_LIT; d.cycles = `OSD_CYC_SUB_LIT; end
        `OSD_HI_DIR: begin d.mode = MD_DIR; d.cycles = `OSD_CYC_SUB_DIR; end
        `OSD_HI_LONG: begin d.mode = MD_LONG; d.cycles = `OSD_CYC_SUB_LONG; end
        `OSD_HI_OFS16: begin d.mode = MD_OFS16; d.cycles = `OSD_CYC_SUB_OFS16; end
        `OSD_HI_OFS8: begin d.mode = MD_OFS8; d.cycles = `OSD_CYC_SUB_OFS8; end
        default: begin d.mode = MD_IX; d.cycles = `OSD_CYC_SUB_IX; end
      endcase
    end else if (lo == `OSD_CHK_LO && hi >= `OSD_HI_CHK_DIR && hi <= `OSD_HI_CHK_IX) begin
      d.op = OP_CHK;
      case (hi)
        `OSD_HI_CHK_DIR: begin d.mode = MD_DIR; d.cycles = `OSD_CYC_CHK_DIR; end
        `OSD_HI_CHK_A: begin d.op = OP_CHKA; d.cycles = `OSD_CYC_CHK_A; end
        `OSD_HI_CHK_X: begin d.op = OP_CHKX; d.cycles = `OSD_CYC_CHK_X; end
        `OSD_HI_CHK_OFS8: begin d.mode = MD_OFS8; d.cycles = `OSD_CYC_CHK_OFS8; end
        default: begin d.mode = MD_IX; d.cycles = `OSD_CYC_CHK_IX; end
      endcase
    end else if (d.opcode == `OSD_OPC_TRAP) begin
      d.op = OP_TRAP;
      d.cycles = `OSD_CYC_TRAP;
    end else if (d.opcode == `OSD_OPC_TRAP_RET) begin
      d.op = OP_TRET;
      d.cycles = `OSD_CYC_TRAP_RET;
    end else if (d.opcode == `OSD_OPC_A2X) begin
      d.op = OP_A2X;
      d.cycles = `OSD_CYC_MOVE;
    end else if (d.opcode == `OSD_OPC_X2A) begin
      d.op = OP_X2A;
      d.cycles = `OSD_CYC_MOVE;
    end else if (d.opcode == `OSD_OPC_WAIT) begin
      d.op = OP_WAIT;
      d.cycles = `OSD_CYC_WAIT;
    end
  end

  assign d.nbytes = mode_bytes(d.mode);
endmodule
`default_nettype wire

// File: sim/osd_mem_model.sv
// Zero-wait program and data memory facing the core
`timescale 1ns/1ps
`default_nettype none
module osd_mem_model (
  input wire logic clk_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  initial begin
    last = 8'h00;
    for (int a = 0; a < 65536; a++) begin
      mem[a] = 8'h00;
    end
  end
  // Asynchronous read; an idle bus shows the inverse of the last byte
  assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~last;
  // Writes land at the edge that ends the write cycle
  always @(posedge clk_i) begin
    if (mem_wr_i) begin
      mem[mem_addr_i] <= mem_wdata_i;
    end
    if (mem_rd_i) begin
      last <= mem[mem_addr_i];
    end
  end
endmodule
`default_nettype wire

// File: sim/osd_core_assertions.sv
// Port-level checker for the opcode subset core
`timescale 1ns/1ps
`default_nettype none
module osd_core_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic wake_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic [7:0] acc_o,
  input wire logic [7:0] index_o,
  input wire logic [4:0] flags_o,
  input wire logic [15:0] pc_o,
  input wire logic [7:0] sp_o,
  input wire logic halted_o,
  input wire logic done_o,
  input wire logic illegal_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Opcode fetch that follows a completed instruction
  sequence s_fetch(logic [7:0] op);
    done_o && mem_rd_o && mem_rdata_i == op;
  endsequence
  sequence s_stack;
    mem_wr_o [*5];
  endsequence
  sequence s_vector;
    mem_rd_o && mem_addr_o == 16'hFFFC && flags_o[3] ##1 mem_rd_o && mem_addr_o == 16'hFFFD;
  endsequence
  a_sub_literal: assert property (s_fetch(8'hA0) |-> ##2 done_o
    && acc_o == $past(acc_o, 2) - $past(mem_rdata_i)
    && flags_o[0] == ($past(acc_o, 2) < $past(mem_rdata_i)) && flags_o[4:3] == $past(flags_o[4:3], 2))
    else $error("literal subtract wrong");
  a_move_to_index: assert property (s_fetch(8'h97) |-> ##2 done_o && index_o == $past(acc_o, 2)
    && flags_o == $past(flags_o, 2)) else $error("acc to index move wrong");
  a_move_to_acc: assert property (s_fetch(8'h9F) |-> ##2 done_o && acc_o == $past(index_o, 2)
    && flags_o == $past(flags_o, 2)) else $error("index to acc move wrong");
  a_check_carry: assert property (s_fetch(8'h4D) |-> ##3 done_o && flags_o[0] == $past(flags_o[0], 3)
    && flags_o[1] == ($past(acc_o, 3) == 8'h00)) else $error("acc check wrong");
  a_long_order: assert property (s_fetch(8'hC0) |-> ##1 mem_addr_o == $past(mem_addr_o) + 16'h0001
    ##1 mem_addr_o == $past(mem_addr_o) + 16'h0001
    ##1 mem_addr_o == {$past(mem_rdata_i, 2), $past(mem_rdata_i)} ##1 done_o)
    else $error("long address order wrong");
  a_trap_sequence: assert property (s_fetch(8'h83) |-> ##1 s_stack ##1 s_vector ##3 done_o)
    else $error("trap stacking or vector wrong");
  a_stack_page: assert property (mem_wr_o |-> mem_addr_o[15:8] == 8'h00)
    else $error("stack write outside page zero");
  a_wait_halt: assert property (s_fetch(8'h8F) |-> ##2 halted_o && !flags_o[3])
    else $error("wait did not halt");
  a_halt_quiet: assert property (halted_o |-> !mem_rd_o && !mem_wr_o)
    else $error("bus access while halted");
endmodule
bind osd_core osd_core_assertions u_chk (.clk_i, .rst_i, .mem_rdata_i, .wake_i, .mem_addr_o, .mem_rd_o,
  .mem_wr_o, .mem_wdata_o, .acc_o, .index_o, .flags_o, .pc_o, .sp_o, .halted_o, .done_o, .illegal_o);
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the opcode subset core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [23:0] code; int len; int cyc; logic [7:0] acc; logic [7:0] x; logic [4:0] flg;
    logic [15:0] nxt;} osd_row_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wake_i = 1'b0;
  logic [7:0] rdata, wdata, acc, index, sp;
  logic [15:0] addr, pc;
  logic rd, wr, halted, done, ill;
  logic [4:0] flags;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  int a = 16'h0100;
  // Program rows: bytes, length, cycles, then acc, index, flags, next fetch address
  osd_row_s rows [15] = '{
    '{24'h970000, 1, 2, 8'h00, 8'h00, 5'h08, 16'h0101}, '{24'hA00500, 2, 2, 8'hFB, 8'h00, 5'h0D, 16'h0103},
    '{24'h970000, 1, 2, 8'hFB, 8'hFB, 5'h0D, 16'h0104}, '{24'hB04000, 2, 3, 8'h00, 8'hFB, 5'h0A, 16'h0106},
    '{24'h9F0000, 1, 2, 8'hFB, 8'hFB, 5'h0A, 16'h0107}, '{24'hC01234, 3, 4, 8'h80, 8'hFB, 5'h0C, 16'h010A},
    '{24'hD01200, 3, 5, 8'hFF, 8'hFB, 5'h0D, 16'h010D}, '{24'hE00500, 2, 4, 8'h68, 8'hFB, 5'h08, 16'h010F},
    '{24'hF00000, 1, 3, 8'h00, 8'hFB, 5'h0A, 16'h0110}, '{24'h3D4000, 2, 4, 8'h00, 8'hFB, 5'h0C, 16'h0112},
    '{24'h4D0000, 1, 3, 8'h00, 8'hFB, 5'h0A, 16'h0113}, '{24'h5D0000, 1, 3, 8'h00, 8'hFB, 5'h0C, 16'h0114},
    '{24'h6D4500, 2, 5, 8'h00, 8'hFB, 5'h0A, 16'h0116}, '{24'h7D0000, 1, 4, 8'h00, 8'hFB, 5'h08, 16'h0117},
    '{24'h004001, 3, 5, 8'h00, 8'hFB, 5'h09, 16'h011B}};
  always #12.5 clk_i = ~clk_i;
  osd_core dut (.clk_i(clk_i), .rst_i(rst_i), .mem_rdata_i(rdata), .wake_i(wake_i), .mem_addr_o(addr),
    .mem_rd_o(rd), .mem_wr_o(wr), .mem_wdata_o(wdata), .acc_o(acc), .index_o(index), .flags_o(flags),
    .pc_o(pc), .sp_o(sp), .halted_o(halted), .done_o(done), .illegal_o(ill));
  osd_mem_model u_mem (.clk_i(clk_i), .mem_addr_i(addr), .mem_rd_i(rd), .mem_wr_i(wr), .mem_wdata_i(wdata),
    .mem_rdata_o(rdata));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Count cycles up to the next completion and check where fetching resumes
  task automatic run(input int cyc, input logic [15:0] nxt);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (done !== 1'b1 && n < 30);
    check("cycles", 16'(n), 16'(cyc));
    check("next fetch", addr, nxt);
  endtask
  task automatic close_out;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Cycle ceiling against a hang
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    // Let the memory model clear itself before the program is loaded
    #1;
    foreach (rows[i]) begin
      for (int b = 0; b < rows[i].len; b++) begin
        u_mem.mem[a + b] = rows[i].code[23 - 8 * b -: 8];
      end
      a += rows[i].len;
    end
    // Operand data, a trap byte the branch must skip, and the trap vector
    u_mem.mem[16'h0040] = 8'hFB; u_mem.mem[16'h1234] = 8'h7B; u_mem.mem[16'h12FB] = 8'h81;
    u_mem.mem[16'h00FB] = 8'h68; u_mem.mem[16'h011A] = 8'h83; u_mem.mem[16'h011B] = 8'h8F;
    u_mem.mem[16'h011C] = 8'h9F; u_mem.mem[16'h011D] = 8'h83; u_mem.mem[16'h011E] = 8'h9F;
    u_mem.mem[16'hFFFC] = 8'h02; u_mem.mem[16'hFFFD] = 8'h00; u_mem.mem[16'h0200] = 8'h80;
    repeat (20) @(negedge clk_i);
    check("reset flags", 16'(flags), 16'h0008);
    check("reset sp", 16'(sp), 16'h00FF);
    rst_i = 1'b0;
    foreach (rows[i]) begin
      run(rows[i].cyc, rows[i].nxt);
      check("acc", 16'(acc), 16'(rows[i].acc));
      check("index", 16'(index), 16'(rows[i].x));
      check("flags", 16'(flags), 16'(rows[i].flg));
      check("pc", pc, rows[i].nxt);
      check("no illegal", 16'(ill), 16'h0000);
    end
    // Wait halts with the mask cleared until woken
    repeat (2) @(negedge clk_i);
    check("halted", 16'(halted), 16'h0001);
    check("wait flags", 16'(flags), 16'h0001);
    repeat (3) @(negedge clk_i);
    check("halted read", 16'(rd), 16'h0000);
    wake_i = 1'b1;
    run(3, 16'h011D);
    wake_i = 1'b0;
    // Trap from an unmasked state, then return
    run(10, 16'h0200);
    check("trap flags", 16'(flags), 16'h0009);
    check("trap sp", 16'(sp), 16'h00FA);
    check("stack pcl", 16'(u_mem.mem[16'h00FF]), 16'h001E);
    check("stack pch", 16'(u_mem.mem[16'h00FE]), 16'h0001);
    check("stack x", 16'(u_mem.mem[16'h00FD]), 16'h00FB);
    check("stack acc", 16'(u_mem.mem[16'h00FC]), 16'h00FB);
    check("stack flags", 16'(u_mem.mem[16'h00FB]), 16'h00E1);
    run(9, 16'h011E);
    check("return flags", 16'(flags), 16'h0001);
    check("return sp", 16'(sp), 16'h00FF);
    check("return pc", pc, 16'h011E);
    check("return acc", 16'(acc), 16'h00FB);
    // A move, then an opcode outside the subset runs as a flagged two-cycle no-op
    u_mem.mem[16'h011F] = 8'h9D;
    run(2, 16'h011F);
    run(2, 16'h0120);
    check("illegal", 16'(ill), 16'h0001);
    check("illegal flags", 16'(flags), 16'h0001);
    // Reset in mid-run returns the registers to their reset values
    rst_i = 1'b1;
    @(negedge clk_i);
    check("rerun pc", pc, 16'h0100);
    check("rerun acc", 16'(acc), 16'h0000);
    check("rerun sp", 16'(sp), 16'h00FF);
    check("rerun flags", 16'(flags), 16'h0008);
    check("rerun halted", 16'(halted), 16'h0000);
    rst_i = 1'b0;
    run(2, 16'h0101);
    check("rerun index", 16'(index), 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
